// File: hw/serial_dac_word_loader.sv
// file holds the serial word loader and data latch of the dac front end
`timescale 1ns/1ps
// Notes on behaviour
// - load select low lets shift clock shift data
// - load select rising latches word, ignores clock
// - data captured on rising shift clock edge
// - unipolar clear forces latch to zero immediately
// - bipolar clear forces latch to midscale
// - word shifted most significant bit first
// - long word keeps last sixteen bits
// - low resolutions left-justified, trailing bits ignored
module serial_dac_word_loader
   import dac_loader_pkg::*;
#(
   parameter bit BIPOLAR    = 1'b0,                      // 1: clear to midscale
   parameter int RESOLUTION = RES_16                     // 16, 14 or 12
) (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   // serial link pins
   input  wire logic        i_load_sel_n,
   input  wire logic        i_shift_clk,
   input  wire logic        i_serial_data,
   input  wire logic        i_async_clear_n,
   // converter side
   output logic [15:0]      o_dac_code,
   output logic             o_word_short,
   output logic             o_update
);
   // synchronised pin views; every pin passes two flops before use, except the clear pin at the latch
   logic sel_n_lvl;                                      // load select level, low in a frame
   logic sel_rise;                                       // end of frame
   logic sck_rise;                                       // rising shift clock edge
   logic din_lvl;                                        // data level, same delay as clock
   logic clear_n_lvl;                                    // clear level, synchronous copy

   // shift state
   logic [15:0]      shift_reg;                          // serial input register
   logic [15:0]      shift_next;                         // shift register after this cycle
   logic [CNT_W-1:0] cnt_reg;                            // edges in this frame, saturating
   logic [CNT_W-1:0] cnt_next;                           // count after this cycle

   // output state
   logic [15:0]      latch_reg;                          // converter data latch
   logic             short_reg;                          // last frame was short
   logic             upd_reg;                            // one-cycle update pulse

   // decode of clear value and used-bit mask; all fixed by parameters
   // midscale sits in the msb for every resolution because codes are left-justified
   wire  [15:0] mid_code   = (RESOLUTION == RES_12) ? MID_CODE_12 :
                             (RESOLUTION == RES_14) ? MID_CODE_14 : MID_CODE_16;
   // unused low bits are forced to zero rather than trusted from the host
   wire  [15:0] used_mask  = (RESOLUTION == RES_12) ? MASK_12 :
                             (RESOLUTION == RES_14) ? MASK_14 : MASK_16;
   wire  [15:0] clear_code = BIPOLAR ? mid_code : ZERO_CODE;
   // a shift needs a clock edge inside a frame
   wire         shift_en   = ~sel_n_lvl & sck_rise;
   // a load needs the end of a frame with clear released
   wire         load_en    = sel_rise & clear_n_lvl;

   // frame timing in core cycles, counted from a pin change at edge n:
   //   first flop takes it at n+1, stable copy at n+2
   //   the shift or the load it causes is applied at edge n+3
   //   o_update is high for the cycle that follows edge n+3
   // data must therefore stay put for two core cycles after the shift clock rises

   // the shift clock is found by sampling, so it must stay well below the core clock:
   // each level has to last at least two core cycles or an edge is lost
   pin_sync #(.RESET_VAL(1'b1)) u_sel (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pin      (i_load_sel_n),
      .o_level    (sel_n_lvl),
      .o_rise     (sel_rise),
      .o_fall     ()
   );
   pin_sync #(.RESET_VAL(1'b0)) u_sck (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pin      (i_shift_clk),
      .o_level    (),
      .o_rise     (sck_rise),
      .o_fall     ()
   );
   // data is synchronised in step with the clock so it pairs with the same edge
   pin_sync #(.RESET_VAL(1'b0)) u_din (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pin      (i_serial_data),
      .o_level    (din_lvl),
      .o_rise     (),
      .o_fall     ()
   );
   // clear copy only gates loads; the latch itself reacts to the raw pin
   pin_sync #(.RESET_VAL(1'b1)) u_clear (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_pin      (i_async_clear_n),
      .o_level    (clear_n_lvl),
      .o_rise     (),
      .o_fall     ()
   );

   // next shift value: msb first, oldest bits fall off the top
   assign shift_next = shift_en ? {shift_reg[14:0], din_lvl} : shift_reg;
   // edge count restarts each frame and saturates at a full word
   // saturating keeps a long frame from wrapping back to a short-looking count
   assign cnt_next = sel_n_lvl ? '0 :
                     (shift_en && cnt_reg != FULL_WORD_CNT) ? cnt_reg + 1'b1 : cnt_reg;

   // shift register and counter; idle while load select high
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         // empty register and count after reset
         shift_reg <= ZERO_CODE;
         cnt_reg   <= '0;
      end else begin
         // not cleared between frames, so a short word keeps older bits
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
      end
   end

   // data latch; the clear pin acts without any clock edge
   // release of the raw pin is harmless: loads wait for the synchronised copy
   always_ff @(posedge i_core_clk or posedge i_rst or negedge i_async_clear_n) begin
      if (i_rst) begin
         // power-up value is zero in both variants
         latch_reg <= ZERO_CODE;
      end else if (!i_async_clear_n) begin
         // clear value depends only on parameters, so this stays a constant
         latch_reg <= BIPOLAR ? ((RESOLUTION == RES_16) ? MID_CODE_16 :
                                 (RESOLUTION == RES_14) ? MID_CODE_14 : MID_CODE_12)
                              : ZERO_CODE;
      end else if (load_en) begin
         latch_reg <= shift_reg & used_mask;
      end
   end

   // status: short frame flag and update pulse
   // the pulse follows the load enable, so it lines up with the new latch value
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         // no frame seen yet
         short_reg <= 1'b0;
         upd_reg   <= 1'b0;
      end else begin
         upd_reg <= load_en;
         // judged on the count before it restarts for the next frame
         if (load_en) begin
            short_reg <= (cnt_reg != FULL_WORD_CNT);
         end
      end
   end

   // reset value of latch is zero even in bipolar mode: power-up follows clear pin
   // all three outputs come straight from flops, so the converter sees no glitch
   assign o_dac_code   = latch_reg;
   assign o_word_short = short_reg;
   assign o_update     = upd_reg;

   // checks on shift, load and clear behaviour
   AST_SHIFT_IN: assert property (@(posedge i_core_clk) disable iff (i_rst)
      shift_en |=> shift_reg == {$past(shift_reg[14:0]), $past(din_lvl)})
      else $error("shift register did not take data bit");
   AST_IDLE_HOLD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sel_n_lvl |=> $stable(shift_reg))
      else $error("shift register moved while load select high");
   AST_LOAD: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (load_en && i_async_clear_n) |=>
         (o_dac_code == ($past(shift_reg) & used_mask)) || !i_async_clear_n)
      else $error("latch did not load shifted word");
   AST_UPD_PULSE: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_update |=> !o_update)
      else $error("update pulse lasted more than one cycle");
   AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_rst)
      !i_async_clear_n |-> o_dac_code == clear_code)
      else $error("latch not at clear value during clear");
   AST_CLEAR_WINS: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (sel_rise && !clear_n_lvl) |=> !upd_reg)
      else $error("load accepted while clear held");
   AST_MASK: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (o_dac_code & ~used_mask) == 16'h0000)
      else $error("ignored trailing bits reached latch");
   AST_SHORT: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (load_en && cnt_reg == FULL_WORD_CNT) |=> !o_word_short)
      else $error("full word flagged short");
   AST_SHORT_SET: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (load_en && cnt_reg != FULL_WORD_CNT) |=> o_word_short)
      else $error("short frame not flagged");
   AST_CNT_SAT: assert property (@(posedge i_core_clk) disable iff (i_rst)
      cnt_reg <= FULL_WORD_CNT)
      else $error("edge count passed a full word");
   AST_CNT_RESTART: assert property (@(posedge i_core_clk) disable iff (i_rst)
      sel_n_lvl |=> cnt_reg == '0)
      else $error("edge count not cleared between frames");

   // cover the main scenarios: any load, short and long frames, clear
   COV_LOAD: cover property (@(posedge i_core_clk) disable iff (i_rst) load_en);
   COV_SHORT: cover property (@(posedge i_core_clk) disable iff (i_rst)
      load_en && cnt_reg < FULL_WORD_CNT);
   COV_LONG: cover property (@(posedge i_core_clk) disable iff (i_rst)
      shift_en && cnt_reg == FULL_WORD_CNT);
   COV_CLEAR: cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(i_async_clear_n));
   COV_CLEAR_BLOCK: cover property (@(posedge i_core_clk) disable iff (i_rst)
      sel_rise && !clear_n_lvl);
endmodule : serial_dac_word_loader

// File: hw/dac_loader_pkg.sv
// package: constants for the serial dac word loader
package dac_loader_pkg;
   localparam int          WORD_W        = 16;           // shift register and latch width
   localparam int          CNT_W         = 5;            // edge counter width
   localparam logic [4:0]  FULL_WORD_CNT = 5'h10;        // edges in one complete word
   localparam logic [15:0] ZERO_CODE     = 16'h0000;     // unipolar clear value
   localparam logic [15:0] MID_CODE_16   = 16'h8000;     // bipolar clear, 16-bit variant
   localparam logic [15:0] MID_CODE_14   = 16'h8000;     // 14-bit code is left-justified
   localparam logic [15:0] MID_CODE_12   = 16'h8000;     // 12-bit code is left-justified
   localparam logic [15:0] MASK_16       = 16'hFFFF;     // used bits, 16-bit variant
   localparam logic [15:0] MASK_14       = 16'hFFFC;     // used bits, 14-bit variant
   localparam logic [15:0] MASK_12       = 16'hFFF0;     // used bits, 12-bit variant
   localparam int          RES_16        = 16;           // resolution selectors
   localparam int          RES_14        = 14;
   localparam int          RES_12        = 12;
endpackage : dac_loader_pkg

// File: hw/pin_sync.sv
// file holds a two-flop synchroniser with rising-edge detect
`timescale 1ns/1ps
module pin_sync
   import dac_loader_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0                      // idle level of the pin
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   // pin side
   input  wire logic i_pin,
   // synchronised side
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_reg;                                       // first stage, read only by stage two
   logic sync_reg;                                       // stable copy
   logic prev_reg;                                       // previous stable copy

   // three-stage shift; edges seen only on stable stages
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
         prev_reg <= RESET_VAL;
      end else begin
         meta_reg <= i_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~prev_reg;
   assign o_fall  = ~sync_reg & prev_reg;
endmodule : pin_sync

// File: dv/dac_host_model.sv
// host side model: drives the three-wire serial link
`timescale 1ns/1ps
module dac_host_model (
   // core clock for pacing
   input  wire logic i_core_clk,
   // serial link
   output logic      o_load_sel_n,
   output logic      o_shift_clk,
   output logic      o_serial_data
);
   // link idles with select high and clock parked low
   initial begin
      o_load_sel_n  = 1'b1;
      o_shift_clk   = 1'b0;
      o_serial_data = 1'b0;
   end
   // send the low n bits of w, 400 ns link period; n below 16 is a deliberate short word
   task automatic send(input logic [19:0] w, input int n);
      @(posedge i_core_clk);
      o_load_sel_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (4) @(posedge i_core_clk);
         o_shift_clk   <= 1'b0;
         o_serial_data <= w[i];
         repeat (4) @(posedge i_core_clk);
         o_shift_clk   <= 1'b1;
      end
      repeat (4) @(posedge i_core_clk);
      o_shift_clk   <= 1'b0;
      o_serial_data <= ~o_serial_data;                // released line shows no stale bit
      repeat (4) @(posedge i_core_clk);
      o_load_sel_n  <= 1'b1;
   endtask : send
endmodule : dac_host_model

// File: dv/serial_dac_word_loader_tb_top.sv
// testbench for the serial dac word loader
`timescale 1ns/1ps
module serial_dac_word_loader_tb_top;
   import dac_loader_pkg::*;
   typedef struct {logic [19:0] w; int n; logic [15:0] code; logic short_f;} row_t;
   logic        i_core_clk      = 1'b0;  // 20 MHz core clock
   logic        i_rst           = 1'b1;  // held for two cycles
   logic        i_async_clear_n = 1'b1;  // clear pin, inactive
   logic        load_sel_n, shift_clk, serial_data;
   logic [15:0] code_a, code_b;          // unipolar 16-bit, bipolar 12-bit
   logic        short_a, update_a;
   int          bad_count = 0, samples_checked = 0, cycles = 0;
   // word, bit count, expected code, expected short flag
   row_t        rows[5] = '{'{20'h0A5C3, 16, 16'hA5C3, 1'b0}, '{20'hF1234, 20, 16'h1234, 1'b0},
                            '{20'h0005A, 8, 16'h0000, 1'b1}, '{20'h08001, 16, 16'h8001, 1'b0},
                            '{20'h0FFFF, 16, 16'hFFFF, 1'b0}};
   always #25 i_core_clk = ~i_core_clk;
   dac_host_model host (.i_core_clk(i_core_clk), .o_load_sel_n(load_sel_n),
      .o_shift_clk(shift_clk), .o_serial_data(serial_data));
   serial_dac_word_loader uut (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_load_sel_n(load_sel_n), .i_shift_clk(shift_clk), .i_serial_data(serial_data),
      .i_async_clear_n(i_async_clear_n), .o_dac_code(code_a), .o_word_short(short_a),
      .o_update(update_a));
   // second variant shares the link: bipolar, 12-bit
   serial_dac_word_loader #(.BIPOLAR(1'b1), .RESOLUTION(RES_12)) uut_bip (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_load_sel_n(load_sel_n),
      .i_shift_clk(shift_clk), .i_serial_data(serial_data),
      .i_async_clear_n(i_async_clear_n), .o_dac_code(code_b), .o_word_short(),
      .o_update());
   // compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // verdict and end of run
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   // hang guard, well above the roughly 1050 cycles needed
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         summarize();
      end
   end
   // main sequence
   initial begin
      @(posedge i_core_clk);
      #1;
      check("code in reset", code_a, ZERO_CODE);
      check("update in reset", {15'h0, update_a}, 16'h0);
      @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      foreach (rows[i]) begin
         host.send(rows[i].w, rows[i].n);
         // load lands at the third edge after load select rises
         repeat (3) @(posedge i_core_clk);
         #1;
         check("update pulse", {15'h0, update_a}, 16'h1);
         check("short flag", {15'h0, short_a}, {15'h0, rows[i].short_f});
         if (!rows[i].short_f) begin
            check("latched word", code_a, rows[i].code);
            check("12-bit word", code_b, rows[i].code & MASK_12);
         end
         @(posedge i_core_clk);
         #1;
         check("update length", {15'h0, update_a}, 16'h0);
      end
      // clear acts at once and blocks a load while held
      @(posedge i_core_clk);
      i_async_clear_n <= 1'b0;
      #1;
      check("clear unipolar", code_a, ZERO_CODE);
      check("clear bipolar", code_b, MID_CODE_12);
      host.send(20'h0BEEF, 16);
      repeat (3) @(posedge i_core_clk);
      #1;
      check("update under clear", {15'h0, update_a}, 16'h0);
      check("code under clear", code_a, ZERO_CODE);
      check("bipolar under clear", code_b, MID_CODE_12);
      @(posedge i_core_clk);
      i_async_clear_n <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      // loads resume once clear is released; a short frame raises the flag
      host.send(20'h000A5, 8);
      repeat (3) @(posedge i_core_clk);
      #1;
      check("update after clear", {15'h0, update_a}, 16'h1);
      check("short after clear", {15'h0, short_a}, 16'h1);
      // reset in mid-run returns the outputs to their idle values
      @(posedge i_core_clk);
      i_rst <= 1'b1;
      #1;
      check("code in second reset", code_a, ZERO_CODE);
      check("short in second reset", {15'h0, short_a}, 16'h0);
      repeat (2) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      host.send(20'h01357, 16);
      repeat (3) @(posedge i_core_clk);
      #1;
      check("word after reset", code_a, 16'h1357);
      check("short after reset", {15'h0, short_a}, 16'h0);
      summarize();
   end
endmodule : serial_dac_word_loader_tb_top
